/* scl_map.vh */
// Strap latch constants: pin indices, codes, defaults and timing counts
`ifndef SCL_MAP_VH
`define SCL_MAP_VH
// ==========================================
// Strap vector bit positions
`define SCL_B_FWD 0
`define SCL_B_IBM 1
`define SCL_B_ROLE 2
`define SCL_B_SPD 3
`define SCL_B_HLO 4
`define SCL_B_HHI 5
`define SCL_B_MLO 6
`define SCL_B_MHI 7
`define SCL_B_PEV 8
`define SCL_B_CHI 9
`define SCL_B_TA 10
`define SCL_B_TB 11
`define SCL_NSTRAP 12
// Reset value of the latch: default strap levels, copper auto-negotiation, test straps low
`define SCL_RST_STRAPS 12'h10F
// ==========================================
// Host interface codes
`define SCL_HIF_MII 2'h0
`define SCL_HIF_RMII 2'h1
`define SCL_HIF_RSVD 2'h2
`define SCL_HIF_RGMII 2'h3
// Management interface codes (output encoding)
`define SCL_MIF_MDIO 2'h0
`define SCL_MIF_I2C 2'h1
`define SCL_MIF_SPI 2'h2
// Copper configuration codes
`define SCL_CU_RSVD 2'h0
`define SCL_CU_ANEG 2'h1
`define SCL_CU_MDIX 2'h2
`define SCL_CU_MDI 2'h3
// ==========================================
// Strap settle window in ns and derived cycles at 50 ns period
`define SCL_SETTLE_NS 200
`define SCL_CLK_NS 50
`define SCL_SETTLE_CYC ((`SCL_SETTLE_NS + `SCL_CLK_NS - 1) / `SCL_CLK_NS)
`endif

/* scl_sync.v */
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module scl_sync #(
  parameter W = 12
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta;
  // ==========================================
  // Synchroniser stages; first stage read only by second
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      meta <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // scl_sync

/* scl_strap_config_latch.v */
// Strap sampling latch and startup configuration decoder
`timescale 1ns/1ps
`include "scl_map.vh"
module scl_strap_config_latch #(
  parameter SETTLE_CYC = `SCL_SETTLE_CYC
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_sys_reset_n,
  input wire i_sw_reset,
  input wire i_power_down,
  input wire i_start_switch,
  input wire i_forward_start_strap,
  input wire i_inband_mgmt_strap,
  input wire i_host_port_role_strap,
  input wire i_host_port_speed_strap,
  input wire i_host_if_sel_hi,
  input wire i_host_if_sel_lo,
  input wire i_mgmt_if_sel_hi,
  input wire i_mgmt_if_sel_lo,
  input wire i_copper_cfg_hi,
  input wire i_power_event_pin,
  input wire i_test_mode_strap_a,
  input wire i_test_mode_strap_b,
  input wire i_led_fwd_n,
  input wire i_led_ibm_n,
  input wire i_led_role_n,
  input wire i_led_spd_n,
  input wire i_power_event_out,
  output reg o_strap_phase,
  output reg o_led_fwd_n,
  output reg o_led_fwd_oe,
  output reg o_led_ibm_n,
  output reg o_led_ibm_oe,
  output reg o_led_role_n,
  output reg o_led_role_oe,
  output reg o_led_spd_n,
  output reg o_led_spd_oe,
  output reg o_power_event_out,
  output reg o_power_event_oe,
  output reg o_forward_enable,
  output reg o_inband_management,
  output reg [1:0] o_host_if_mode,
  output reg o_host_if_reserved,
  output reg o_mii_phy_mode,
  output reg o_ref_clock_out_en,
  output reg o_ref_clock_in_sel,
  output reg o_inband_status,
  output reg o_speed_1000,
  output reg [1:0] o_mgmt_if_mode,
  output reg [1:0] o_copper_cfg,
  output reg o_copper_aneg_eee,
  output reg o_copper_force_100fd,
  output reg o_copper_mdix,
  output reg o_copper_reserved,
  output reg o_factory_test
);
  localparam ST_HOLD = 3'b001;
  localparam ST_SETTLE = 3'b010;
  localparam ST_RUN = 3'b100;
  localparam CW = 8;

  // Management code: any code with upper bit set is SPI
  function [1:0] scl_mgmt_dec;
    input [1:0] code;
    begin
      if (code[1])
        scl_mgmt_dec = `SCL_MIF_SPI;
      else if (code[0])
        scl_mgmt_dec = `SCL_MIF_I2C;
      else
        scl_mgmt_dec = `SCL_MIF_MDIO;
    end
  endfunction

  wire [`SCL_NSTRAP-1:0] pins_raw;
  wire [`SCL_NSTRAP-1:0] pins;
  wire [2:0] ctl;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [CW-1:0] cnt;
  reg [`SCL_NSTRAP-1:0] straps;
  reg run_q;
  reg fwd_started;
  wire in_reset;
  wire sys_rst_n_s;
  wire sw_rst_s;
  wire pdown_s;
  wire start_s;

  assign pins_raw = {i_test_mode_strap_b, i_test_mode_strap_a, i_copper_cfg_hi, i_power_event_pin,
    i_mgmt_if_sel_hi, i_mgmt_if_sel_lo, i_host_if_sel_hi, i_host_if_sel_lo,
    i_host_port_speed_strap, i_host_port_role_strap, i_inband_mgmt_strap, i_forward_start_strap};

  // ==========================================
  // Pin and control synchronisers
  scl_sync #(.W(`SCL_NSTRAP)) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // Reset pin and controls may come from another domain
  scl_sync #(.W(3)) u_ctl_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_power_down, i_sw_reset, ~i_sys_reset_n}),
    .o_sync(ctl)
  );
  assign sys_rst_n_s = ~ctl[0];
  assign sw_rst_s = ctl[1];
  assign pdown_s = ctl[2];
  assign start_s = i_start_switch;
  assign in_reset = !sys_rst_n_s || sw_rst_s || pdown_s;

  // ==========================================
  // Sequencer: hold during reset, settle, then sample once
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (!in_reset)
          next_state = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (in_reset)
          next_state = ST_HOLD;
        else if (cnt == SETTLE_CYC[CW-1:0])
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (in_reset)
          next_state = ST_HOLD;
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ST_HOLD;
      cnt <= {CW{1'b0}};
    end else begin
      state <= next_state;
      if (state == ST_SETTLE)
        cnt <= cnt + 1'b1;
      else
        cnt <= {CW{1'b0}};
    end
  end

  // ==========================================
  // Capture at end of settle; held until the end of the next settle
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      straps <= `SCL_RST_STRAPS;
    end else if (state == ST_SETTLE && next_state == ST_RUN) begin
      straps <= pins;
    end
  end

  // Start bit is sticky once set; cleared by any new reset
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      fwd_started <= 1'b0;
      run_q <= 1'b0;
    end else begin
      run_q <= (state == ST_RUN) && (next_state == ST_RUN);
      if (state != ST_RUN)
        fwd_started <= 1'b0;
      else if (start_s)
        fwd_started <= 1'b1;
    end
  end

  // ==========================================
  // Pin direction: inputs during reset and settle, outputs in run
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_strap_phase <= 1'b1;
      o_led_fwd_oe <= 1'b0;
      o_led_ibm_oe <= 1'b0;
      o_led_role_oe <= 1'b0;
      o_led_spd_oe <= 1'b0;
      o_power_event_oe <= 1'b0;
      o_led_fwd_n <= 1'b1;
      o_led_ibm_n <= 1'b1;
      o_led_role_n <= 1'b1;
      o_led_spd_n <= 1'b1;
      o_power_event_out <= 1'b1;
    end else begin
      o_strap_phase <= !run_q;
      o_led_fwd_oe <= run_q;
      o_led_ibm_oe <= run_q;
      o_led_role_oe <= run_q;
      o_led_spd_oe <= run_q;
      o_power_event_oe <= run_q;
      o_led_fwd_n <= i_led_fwd_n;
      o_led_ibm_n <= i_led_ibm_n;
      o_led_role_n <= i_led_role_n;
      o_led_spd_n <= i_led_spd_n;
      o_power_event_out <= i_power_event_out;
    end
  end

  // ==========================================
  // Configuration decode from the latched straps
  always @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_forward_enable <= 1'b0;
      o_inband_management <= 1'b0;
      o_host_if_mode <= `SCL_HIF_MII;
      o_host_if_reserved <= 1'b0;
      o_mii_phy_mode <= 1'b0;
      o_ref_clock_out_en <= 1'b0;
      o_ref_clock_in_sel <= 1'b0;
      o_inband_status <= 1'b0;
      o_speed_1000 <= 1'b0;
      o_mgmt_if_mode <= `SCL_MIF_MDIO;
      o_copper_cfg <= `SCL_CU_ANEG;
      o_copper_aneg_eee <= 1'b1; // Matches the auto-negotiation code shown on o_copper_cfg
      o_copper_force_100fd <= 1'b0;
      o_copper_mdix <= 1'b0;
      o_copper_reserved <= 1'b0;
      o_factory_test <= 1'b0;
    end else begin
      // No forwarding while in reset; strap low waits for start bit
      o_forward_enable <= (state == ST_RUN) && (straps[`SCL_B_FWD] || fwd_started);
      o_inband_management <= !straps[`SCL_B_IBM];
      o_host_if_mode <= {straps[`SCL_B_HHI], straps[`SCL_B_HLO]};
      o_host_if_reserved <= ({straps[`SCL_B_HHI], straps[`SCL_B_HLO]} == `SCL_HIF_RSVD);
      o_mii_phy_mode <= ({straps[`SCL_B_HHI], straps[`SCL_B_HLO]} == `SCL_HIF_MII) && !straps[`SCL_B_ROLE];
      o_ref_clock_out_en <= ({straps[`SCL_B_HHI], straps[`SCL_B_HLO]} == `SCL_HIF_RMII)
        && !straps[`SCL_B_ROLE];
      o_ref_clock_in_sel <= ({straps[`SCL_B_HHI], straps[`SCL_B_HLO]} == `SCL_HIF_RMII)
        && straps[`SCL_B_ROLE];
      o_inband_status <= ({straps[`SCL_B_HHI], straps[`SCL_B_HLO]} == `SCL_HIF_RGMII)
        && straps[`SCL_B_ROLE];
      o_speed_1000 <= !straps[`SCL_B_SPD];
      o_mgmt_if_mode <= scl_mgmt_dec({straps[`SCL_B_MHI], straps[`SCL_B_MLO]});
      o_copper_cfg <= {straps[`SCL_B_CHI], straps[`SCL_B_PEV]};
      o_copper_aneg_eee <= ({straps[`SCL_B_CHI], straps[`SCL_B_PEV]} == `SCL_CU_ANEG);
      o_copper_reserved <= ({straps[`SCL_B_CHI], straps[`SCL_B_PEV]} == `SCL_CU_RSVD);
      o_copper_force_100fd <= straps[`SCL_B_CHI];
      o_copper_mdix <= ({straps[`SCL_B_CHI], straps[`SCL_B_PEV]} == `SCL_CU_MDIX);
      o_factory_test <= straps[`SCL_B_TA] || straps[`SCL_B_TB];
    end
  end
endmodule // scl_strap_config_latch

/* scl_board.sv */
// Board pull resistors and shared-pin wiring around the strap latch
`timescale 1ns/1ps
// ==========
// Board model
module scl_board (
  input wire [11:0] i_pull,
  input wire [4:0] i_oe,
  input wire [4:0] i_drv,
  output wire [11:0] o_pin
);
  // A driven LED or event pin overrides its pull resistor
  assign o_pin = {2'h0,
    i_pull[9], i_oe[4] ? i_drv[4] : i_pull[8],
    i_pull[7:4], (i_oe[3:0] & i_drv[3:0]) | (~i_oe[3:0] & i_pull[3:0])};
endmodule // scl_board

/* scl_latch_assertions.sv */
// Concurrent checks on the strap latch ports
`timescale 1ns/1ps
// ==========
// Checker
module scl_latch_assertions (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_sys_reset_n,
  input wire i_start_switch,
  input wire o_strap_phase,
  input wire o_forward_enable,
  input wire [1:0] o_host_if_mode,
  input wire o_mii_phy_mode,
  input wire o_ref_clock_out_en,
  input wire o_ref_clock_in_sel,
  input wire o_inband_status,
  input wire [1:0] o_mgmt_if_mode,
  input wire [1:0] o_copper_cfg,
  input wire o_copper_aneg_eee,
  input wire o_copper_mdix
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Role outputs only in their own host mode
  mii_role_a: assert property (o_mii_phy_mode |-> o_host_if_mode == 2'h0) else $error("phy role");
  ref_clock_a: assert property (o_ref_clock_out_en |-> o_host_if_mode == 2'h1 && !o_ref_clock_in_sel)
    else $error("ref clock");
  inband_stat_a: assert property (o_inband_status |-> o_host_if_mode == 2'h3) else $error("status");
  mgmt_code_a: assert property (o_mgmt_if_mode != 2'h3) else $error("mgmt code");
  copper_dec_a: assert property (o_copper_aneg_eee == (o_copper_cfg == 2'h1)
    && o_copper_mdix == (o_copper_cfg == 2'h2)) else $error("copper");
  // Sync delay of the reset pin is two flops, so a few cycles suffice
  phase_entry_a: assert property ($fell(i_sys_reset_n) |-> ##[1:4] o_strap_phase) else $error("phase");
  hold_cfg_a: assert property (!o_strap_phase && !$past(o_strap_phase) |-> $stable(o_host_if_mode)
    && $stable(o_copper_cfg) && $stable(o_mgmt_if_mode)) else $error("held cfg");
  fwd_wait_a: assert property (!o_strap_phase && !o_forward_enable && !i_start_switch |=>
    !o_forward_enable) else $error("early fwd");
  fwd_start_a: assert property (!o_strap_phase && i_start_switch |-> ##[1:2] o_forward_enable)
    else $error("no fwd");
endmodule // scl_latch_assertions
bind scl_strap_config_latch scl_latch_assertions u_scl_latch_assertions (.*);

/* scl_strap_config_latch_tb.sv */
// Self-checking bench for the strap latch
`timescale 1ns/1ps
// ==========
// Bench top
module scl_strap_config_latch_tb;
  logic i_core_clk, i_rst_n, i_sys_reset_n, i_sw_reset, i_power_down, i_start_switch;
  logic i_forward_start_strap, i_inband_mgmt_strap, i_host_port_role_strap, i_host_port_speed_strap;
  logic i_host_if_sel_hi, i_host_if_sel_lo, i_mgmt_if_sel_hi, i_mgmt_if_sel_lo, i_copper_cfg_hi;
  logic i_power_event_pin, i_test_mode_strap_a, i_test_mode_strap_b, i_led_fwd_n, i_led_ibm_n;
  logic i_led_role_n, i_led_spd_n, i_power_event_out, o_strap_phase, o_led_fwd_n, o_led_fwd_oe;
  logic o_led_ibm_n, o_led_ibm_oe, o_led_role_n, o_led_role_oe, o_led_spd_n, o_led_spd_oe;
  logic o_power_event_out, o_power_event_oe, o_forward_enable, o_inband_management, o_host_if_reserved;
  logic o_mii_phy_mode, o_ref_clock_out_en, o_ref_clock_in_sel, o_inband_status, o_speed_1000;
  logic o_copper_aneg_eee, o_copper_force_100fd, o_copper_mdix, o_copper_reserved, o_factory_test;
  logic [1:0] o_host_if_mode, o_mgmt_if_mode, o_copper_cfg;
  logic [11:0] pull, pin;
  int bad_count, cmp_count;
  // Short settle keeps each capture brief
  scl_strap_config_latch #(.SETTLE_CYC(1)) u_scl_strap_config_latch (.*);
  scl_board u_scl_board (.i_pull(pull), .i_oe({o_power_event_oe, o_led_spd_oe, o_led_role_oe, o_led_ibm_oe,
    o_led_fwd_oe}), .i_drv({o_power_event_out, o_led_spd_n, o_led_role_n, o_led_ibm_n, o_led_fwd_n}), .o_pin(pin));
  assign {i_test_mode_strap_b, i_test_mode_strap_a, i_copper_cfg_hi, i_power_event_pin, i_mgmt_if_sel_hi,
    i_mgmt_if_sel_lo, i_host_if_sel_hi, i_host_if_sel_lo, i_host_port_speed_strap, i_host_port_role_strap,
    i_inband_mgmt_strap, i_forward_start_strap} = pin;
  always #25 i_core_clk = ~i_core_clk;
  // ==========
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Reset of kind t (pin, software, power-down) with pulls p, then wait for run
  task automatic cap(input logic [11:0] p, input int t);
    int n;
    @(posedge i_core_clk);
    pull <= p;
    i_start_switch <= 1'b0;
    i_sys_reset_n <= (t != 0);
    i_sw_reset <= (t == 1);
    i_power_down <= (t == 2);
    repeat (4) @(posedge i_core_clk);
    #1 chk("strap_oe", {o_strap_phase, o_led_fwd_oe, o_power_event_oe}, 3'h4);
    @(posedge i_core_clk);
    {i_sys_reset_n, i_sw_reset, i_power_down} <= 3'h4;
    for (n = 0; n < 40 && o_strap_phase !== 1'b0; n++) begin
      @(posedge i_core_clk);
      #1;
    end
    chk("run_wait", n < 40, 1'b1);
  endtask
  // ==========
  // Every interface code with both role levels, each reset kind in turn
  task automatic t_decode;
    logic [11:0] p;
    logic [1:0] c;
    logic r;
    for (int j = 0; j < 8; j++) begin
      c = j[1:0];
      r = j[2];
      p = {2'h0, c, c, c, c != 2'h3, r, c == 2'h1 | r, 1'b1};
      cap(p, j % 3);
      chk("host", {o_host_if_mode, o_host_if_reserved, o_mii_phy_mode, o_ref_clock_out_en, o_ref_clock_in_sel,
        o_inband_status, o_speed_1000, o_inband_management}, {c, c == 2'h2, c == 2'h0 & !r, c == 2'h1 & !r,
        c == 2'h1 & r, c == 2'h3 & r, c == 2'h3, !p[1]});
      chk("mgmt_cu", {o_mgmt_if_mode, o_copper_cfg, o_copper_aneg_eee, o_copper_force_100fd, o_copper_mdix,
        o_copper_reserved, o_forward_enable, o_factory_test}, {c[1] ? 2'h2 : c, c, c == 2'h1, c[1],
        c == 2'h2, c == 2'h0, 2'h2});
    end
    $display("test decode done");
  endtask
  // Forwarding held off, then started; pin changes in run are ignored
  task automatic t_forward;
    cap(12'h10A, 0);
    repeat (5) @(posedge i_core_clk);
    #1 chk("fwd_wait", o_forward_enable, 1'b0);
    @(posedge i_core_clk);
    pull <= 12'h20B;
    i_start_switch <= 1'b1;
    i_led_fwd_n <= 1'b0;
    i_led_ibm_n <= 1'b0;
    i_led_spd_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1 chk("fwd_go", {o_forward_enable, o_led_fwd_n, o_led_fwd_oe, pin[0], o_copper_cfg, o_inband_management},
      {4'hA, 2'h1, 1'b0});
    // Driven levels differ from the pulls on every shared pin
    chk("pins_run", {o_led_ibm_n, o_led_role_n, o_led_spd_n, o_power_event_out, o_led_ibm_oe, o_led_role_oe,
      o_led_spd_oe, o_power_event_oe, pin[3:1], pin[8]}, 12'h5F5);
    // A new reset must clear the sticky start bit
    cap(12'h10A, 1);
    chk("fwd_clear", o_forward_enable, 1'b0);
    $display("test forward done");
  endtask
  // ==========
  // Main sequence and watchdog
  initial begin
    {i_core_clk, i_rst_n, i_sw_reset, i_power_down, i_start_switch} = 5'h0;
    {i_sys_reset_n, i_led_fwd_n, i_led_ibm_n, i_led_role_n, i_led_spd_n, i_power_event_out} = 6'h3F;
    pull = 12'h10F;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_decode;
    t_forward;
    tally_and_finish;
  end
  // Whole run needs under two hundred cycles; this bound is generous
  initial begin
    #(50 * 3000);
    bad_count++;
    tally_and_finish;
  end
endmodule // scl_strap_config_latch_tb
